// file: rtl/dab_pkg.sv
// Constants, field layout and types for the dual converter back end
package dab_pkg;

  localparam int DAB_W       = 10;
  localparam int NCH         = 2;
  localparam int PIPE_DEPTH  = 9;
  localparam int BUILT_IN_SELF_CHECK_CYCLES = 512;

  // Register offsets on the configuration port
  localparam logic [7:0] REG_CHAN_SEL = 8'h05;
  localparam logic [7:0] REG_POWER    = 8'h08;
  localparam logic [7:0] REG_TEST     = 8'h0d;
  localparam logic [7:0] REG_BUILT_IN_SELF_CHECK     = 8'h0e;
  localparam logic [7:0] REG_OUT_MODE = 8'h14;
  localparam logic [7:0] REG_BUILT_IN_SELF_CHECK_RES = 8'h24;

  // Field positions
  localparam int OM_FMT_LSB      = 0;
  localparam int OM_OEB_BIT      = 4;
  localparam int OM_DCO_INV_BIT  = 7;
  localparam int BUILT_IN_SELF_CHECK_EN_BIT     = 0;
  localparam int PN_RESTART_BIT_BIT   = 2;
  localparam int RES_PASS_BIT    = 0;
  localparam int RES_BUSY_BIT    = 1;
  localparam int TM_RST_LONG_BIT = 4;
  localparam int TM_RST_SHRT_BIT = 5;

  // Values after reset
  localparam logic [7:0]  CHAN_SEL_RST = 8'h03;
  localparam logic [7:0]  OUT_MODE_RST = 8'h00;
  localparam logic [7:0]  TEST_RST     = 8'h00;
  localparam logic [7:0]  BUILT_IN_SELF_CHECK_RST     = 8'h00;
  localparam logic [1:0]  POWER_RST    = 2'h0;
  localparam logic [15:0] BUILT_IN_SELF_CHECK_SEED    = 16'hffff;
  localparam logic [15:0] CRC_SEED     = 16'hffff;
  localparam logic [22:0] PN_LONG_SEED = 23'h7fffff;
  localparam logic [8:0]  PN_SHRT_SEED = 9'h1ff;

  typedef enum logic [1:0] {FMT_OFFSET = 2'h0, FMT_TWOS = 2'h1, FMT_GRAY = 2'h2} dab_fmt_t;
  typedef enum logic [1:0] {PWR_RUN = 2'h0, PWR_DOWN = 2'h1, PWR_STBY = 2'h2} dab_pwr_t;
  typedef enum logic [3:0] {
    TM_OFF = 4'h0, TM_MID = 4'h1, TM_POS = 4'h2, TM_NEG = 4'h3,
    TM_CHK = 4'h4, TM_PNL = 4'h5, TM_PNS = 4'h6, TM_TGL = 4'h7
  } dab_tm_t;
  typedef enum logic [1:0] {BST_IDLE = 2'b00, BST_RUN = 2'b01, BST_CHECK = 2'b11} dab_bst_t;

endpackage

// file: rtl/dab_backend.sv
// Output formatting, pipeline, output drivers, power modes and self-test of the dual converter
// Contract
// - Power-down from pin or register
// - Power-down three-states every output driver
// - Pin low returns to normal conversion
// - Register standby keeps reference powered
// - Strap selects offset binary or twos
// - Registers select offset, twos or gray
// - Offset and twos differ in MSB
// - Output-disable pin high three-states all
// - Bit 4 three-states one channel
// - Nine sample cycles output latency
// - Outputs update on each sample edge
// - Data valid on data clock edge
// - Self-test drives PN, collects CRC
// - Self-test runs 512 cycles then compares
// - Result bit 0 shows pass
// - Outputs stay connected during self-test
// - Write 0x05 starts self-test, restarts PN
// - Without restart PN continues from last
// - Test mode replaces core, gets formatted
// - Bits 4, 5 reset pattern generators
// - Test patterns advance only on samples
`timescale 1ns/10ps
module dab_backend
  import dab_pkg::*;
#(
  parameter int          W              = DAB_W,
  parameter logic [15:0] BUILT_IN_SELF_CHECK_SIGNATURE = 16'h0000
)(
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic                      power_down_pin,
  input  wire logic                      output_disable_pin,
  input  wire logic                      format_strap_pin,
  input  wire logic                      serial_mode,
  input  wire logic                      reg_we,
  input  wire logic                      reg_re,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      sample_tick,
  input  wire logic [NCH-1:0][W+2:0]     core_sample,
  output logic                           core_accept,
  input  wire logic                      capture_ready,
  output logic      [NCH-1:0][W-1:0]     data_out,
  output logic      [NCH-1:0]            over_range_out,
  output logic      [NCH-1:0]            data_clock_out,
  output logic      [NCH-1:0]            data_oe,
  output logic                           core_enable,
  output logic                           reference_on
);

  localparam int             WW   = NCH * (W + 1);
  localparam logic signed [W+2:0] MAXH = (W+3)'(2**(W+1) - 1);
  localparam logic [9:0]     BLAST = 10'(BUILT_IN_SELF_CHECK_CYCLES - 1);

  logic [2:0]            pin_raw;
  logic [2:0][2:0]       sync_q;
  logic [2:0]            pin_q;
  logic                  pd_pin;
  logic                  oeb_pin;
  logic                  dfs_pin;
  logic                  wr;
  logic [7:0]            chan_sel_q;
  dab_pwr_t              pwr_q;
  logic [7:0]            test_q;
  logic [7:0]            built_in_self_check_q;
  logic [NCH-1:0][7:0]   om_q;
  logic                  pd;
  logic                  stby;
  logic                  adv;
  dab_bst_t              bst_q;
  logic [9:0]            bcnt_q;
  logic [15:0]           bpn_q;
  logic [15:0]           crc_q;
  logic                  pass_q;
  logic                  built_in_self_check_run;
  logic                  built_in_self_check_start;
  logic [22:0]           pnl_q;
  logic [8:0]            pns_q;
  logic                  tgl_q;
  logic [W-1:0]          pat;
  logic [PIPE_DEPTH-1:0] vld_q;
  logic [NCH-1:0][W:0]   src_w;
  logic [NCH-1:0][W:0]   fmt_w;
  logic [NCH-1:0][W:0]   pword;
  logic [1:0][WW-1:0]    mem_q;
  logic                  wp_q;
  logic                  rp_q;
  logic [1:0]            cnt_q;
  logic                  buf_wvalid;
  logic                  buf_wready;
  logic                  buf_rvalid;
  logic                  buf_rready;
  logic                  phase_q;
  logic                  dco_q;
  logic [NCH-1:0]        oe_q;
  logic [7:0]            rd_d;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [WW-1:0] d);
    logic [15:0] r;
    r = c;
    for (int i = WW - 1; i >= 0; i--)
    begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a level counts once stages two and three agree
  assign pin_raw = {format_strap_pin, output_disable_pin, power_down_pin};

  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge clock)
    begin
      if (sys_rst)
      begin
        sync_q[i] <= 3'h0;
        pin_q[i]  <= 1'b0;
      end
      else
      begin
        sync_q[i] <= {sync_q[i][1:0], pin_raw[i]};
        if (sync_q[i][1] == sync_q[i][2])
          pin_q[i] <= sync_q[i][2];
      end
    end
  end

  assign pd_pin  = pin_q[0];
  assign oeb_pin = pin_q[1];
  assign dfs_pin = pin_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; writes are ignored in strap mode, reads still work
  assign wr = reg_we && serial_mode;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      chan_sel_q <= CHAN_SEL_RST;
      pwr_q      <= dab_pwr_t'(POWER_RST);
      test_q     <= TEST_RST;
    end
    else if (wr)
    begin
      if (reg_addr == REG_CHAN_SEL)
        chan_sel_q <= reg_wdata;
      if (reg_addr == REG_POWER)
        pwr_q <= dab_pwr_t'(reg_wdata[1:0]);
      if (reg_addr == REG_TEST)
        test_q <= reg_wdata;
    end
  end

  assign pd          = pd_pin || (serial_mode && pwr_q == PWR_DOWN);
  assign stby        = serial_mode && pwr_q == PWR_STBY;
  assign core_enable = !pd && !stby;
  assign reference_on = !pd;
  // Halting the pipe in low power keeps the last samples rather than flushing garbage
  assign adv         = core_enable && (sample_tick || built_in_self_check_run);

  always_comb
  begin
    rd_d = 8'h00;
    unique case (reg_addr)
      REG_CHAN_SEL: rd_d = chan_sel_q;
      REG_POWER:    rd_d = {6'h00, pwr_q};
      REG_TEST:     rd_d = test_q;
      REG_BUILT_IN_SELF_CHECK:     rd_d = built_in_self_check_q;
      REG_OUT_MODE: rd_d = chan_sel_q[0] ? om_q[0] : om_q[1];
      REG_BUILT_IN_SELF_CHECK_RES: rd_d = {6'h00, bst_q != BST_IDLE, pass_q};
      default:      rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_re)
      reg_rdata <= rd_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-test sequencer
  assign built_in_self_check_start = wr && reg_addr == REG_BUILT_IN_SELF_CHECK && reg_wdata[BUILT_IN_SELF_CHECK_EN_BIT] && bst_q == BST_IDLE;
  assign built_in_self_check_run   = bst_q == BST_RUN;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      bst_q  <= BST_IDLE;
      bcnt_q <= 10'h000;
      crc_q  <= CRC_SEED;
      pass_q <= 1'b0;
      built_in_self_check_q <= BUILT_IN_SELF_CHECK_RST;
    end
    else
    begin
      if (wr && reg_addr == REG_BUILT_IN_SELF_CHECK)
        built_in_self_check_q <= reg_wdata;
      unique case (bst_q)
        BST_IDLE:
          if (built_in_self_check_start)
          begin
            bst_q  <= BST_RUN;
            bcnt_q <= 10'h000;
            crc_q  <= CRC_SEED;
            pass_q <= 1'b0;
          end
        BST_RUN:
        begin
          bcnt_q <= bcnt_q + 10'h001;
          crc_q  <= crc_step(crc_q, pword);
          if (bcnt_q == BLAST)
            bst_q <= BST_CHECK;
        end
        BST_CHECK:
        begin
          pass_q <= crc_q == BUILT_IN_SELF_CHECK_SIGNATURE;
          bst_q  <= BST_IDLE;
          if (!(wr && reg_addr == REG_BUILT_IN_SELF_CHECK))
            built_in_self_check_q[BUILT_IN_SELF_CHECK_EN_BIT] <= 1'b0;
        end
        default:
          bst_q <= BST_IDLE;
      endcase
    end
  end

  // Self-test source; it resumes from its last state unless restarted
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      bpn_q <= BUILT_IN_SELF_CHECK_SEED;
    else if (built_in_self_check_start && reg_wdata[PN_RESTART_BIT_BIT])
      bpn_q <= BUILT_IN_SELF_CHECK_SEED;
    else if (built_in_self_check_run && core_enable)
      bpn_q <= {bpn_q[14:0], bpn_q[15] ^ bpn_q[13] ^ bpn_q[12] ^ bpn_q[10]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output test patterns
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pnl_q <= PN_LONG_SEED;
      pns_q <= PN_SHRT_SEED;
      tgl_q <= 1'b0;
    end
    else
    begin
      if (test_q[TM_RST_LONG_BIT])
        pnl_q <= PN_LONG_SEED;
      else if (sample_tick && core_enable)
        pnl_q <= {pnl_q[21:0], pnl_q[22] ^ pnl_q[17]};
      if (test_q[TM_RST_SHRT_BIT])
        pns_q <= PN_SHRT_SEED;
      else if (sample_tick && core_enable)
        pns_q <= {pns_q[7:0], pns_q[8] ^ pns_q[4]};
      if (sample_tick && core_enable)
        tgl_q <= !tgl_q;
    end
  end

  always_comb
  begin
    pat = '0;
    unique case (dab_tm_t'(test_q[3:0]))
      TM_MID:  pat = {1'b1, {(W-1){1'b0}}};
      TM_POS:  pat = '1;
      TM_NEG:  pat = '0;
      TM_CHK:  pat = {(W/2){tgl_q, !tgl_q}};
      TM_PNL:  pat = pnl_q[W-1:0];
      TM_PNS:  pat = pns_q[W-1:0];
      TM_TGL:  pat = {W{tgl_q}};
      default: pat = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel source, clamp, format and pipeline
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic signed [W+2:0]          hv;
    dab_fmt_t                     fmt;
    logic [PIPE_DEPTH-1:0][W:0]   pipe_q;

    assign hv = $signed(core_sample[c]);

    always_comb
    begin
      if (built_in_self_check_run)
        src_w[c] = {1'b0, bpn_q[W-1:0]};
      else if (test_q[3:0] != TM_OFF)
        src_w[c] = {1'b0, pat};
      else if (hv < 0)
        src_w[c] = {1'b1, {W{1'b0}}};
      else if (hv > MAXH)
        src_w[c] = {1'b1, {W{1'b1}}};
      else
        src_w[c] = {1'b0, hv[W:1]};
    end

    assign fmt = serial_mode ? dab_fmt_t'(om_q[c][OM_FMT_LSB +: 2])
                             : (dfs_pin ? FMT_TWOS : FMT_OFFSET);

    always_comb
    begin
      fmt_w[c] = src_w[c];
      unique case (fmt)
        FMT_TWOS: fmt_w[c][W-1] = !src_w[c][W-1];
        FMT_GRAY: fmt_w[c][W-1:0] = src_w[c][W-1:0] ^ (src_w[c][W-1:0] >> 1);
        default:  fmt_w[c] = src_w[c];
      endcase
    end

    always_ff @(posedge clock)
    begin
      if (sys_rst)
        pipe_q <= '0;
      else if (adv)
        pipe_q <= {pipe_q[PIPE_DEPTH-2:0], fmt_w[c]};
    end

    assign pword[c] = pipe_q[PIPE_DEPTH-1];

    always_ff @(posedge clock)
    begin
      if (sys_rst)
        om_q[c] <= OUT_MODE_RST;
      else if (wr && reg_addr == REG_OUT_MODE && chan_sel_q[c])
        om_q[c] <= reg_wdata;
    end

    always_ff @(posedge clock)
    begin
      if (sys_rst)
        oe_q[c] <= 1'b0;
      else
        oe_q[c] <= !pd && !stby && !oeb_pin && !(serial_mode && om_q[c][OM_OEB_BIT]);
    end

    assign data_clock_out[c] = dco_q ^ om_q[c][OM_DCO_INV_BIT];
  end

  assign data_oe = oe_q;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      vld_q <= '0;
    else if (adv)
      vld_q <= {vld_q[PIPE_DEPTH-2:0], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer; a full buffer drops the word and shows it on core_accept
  assign buf_wvalid  = adv && vld_q[PIPE_DEPTH-1];
  assign buf_wready  = cnt_q != 2'h2;
  assign buf_rvalid  = cnt_q != 2'h0;
  assign buf_rready  = !phase_q && capture_ready;
  assign core_accept = buf_wready;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
      mem_q <= '0;
    end
    else
    begin
      if (buf_wvalid && buf_wready)
      begin
        mem_q[wp_q] <= pword;
        wp_q        <= !wp_q;
      end
      if (buf_rvalid && buf_rready)
        rp_q <= !rp_q;
      cnt_q <= cnt_q + 2'(buf_wvalid && buf_wready) - 2'(buf_rvalid && buf_rready);
    end
  end

  // Data changes with the clock low so the rising edge sits mid-word
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      phase_q        <= 1'b0;
      dco_q          <= 1'b0;
      data_out       <= '0;
      over_range_out <= '0;
    end
    else if (buf_rvalid && buf_rready)
    begin
      phase_q <= 1'b1;
      dco_q   <= 1'b0;
      for (int c = 0; c < NCH; c++)
      begin
        data_out[c]       <= mem_q[rp_q][c*(W+1) +: W];
        over_range_out[c] <= mem_q[rp_q][c*(W+1) + W];
      end
    end
    else if (phase_q)
    begin
      phase_q <= 1'b0;
      dco_q   <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Counts back-to-back advances so the latency check needs no long repetition
  logic [3:0] adv_run_q;
  always_ff @(posedge clock)
  begin
    if (sys_rst || !adv)
      adv_run_q <= 4'h0;
    else if (adv_run_q != 4'hf)
      adv_run_q <= adv_run_q + 4'h1;
  end

  logic [9:0] run_len_q;
  always_ff @(posedge clock)
  begin
    if (sys_rst || built_in_self_check_start)
      run_len_q <= 10'h000;
    else if (built_in_self_check_run)
      run_len_q <= run_len_q + 10'h001;
  end

  a_pd_hiz: assert property (pd |=> data_oe == '0) else $error("outputs driven in power-down");
  a_oeb_pin: assert property (oeb_pin |=> data_oe == '0) else $error("outputs driven with pin disable");
  a_oe_on: assert property (!pd && !stby && !oeb_pin && !serial_mode |=> data_oe == '1)
    else $error("outputs not enabled");
  a_chan_oeb: assert property (serial_mode && om_q[0][OM_OEB_BIT] |=> !data_oe[0])
    else $error("channel disable ignored");
  a_pipe_lat: assert property (adv && adv_run_q >= 4'h8 |=> g_ch[0].pipe_q[PIPE_DEPTH-1] == $past(fmt_w[0], 9))
    else $error("pipeline latency wrong");
  a_twos_mid: assert property (serial_mode && om_q[0][1:0] == FMT_TWOS && test_q[3:0] == TM_MID
    && !built_in_self_check_run |-> fmt_w[0] == '0) else $error("twos midscale not zero");
  a_built_in_self_check_len: assert property ($fell(built_in_self_check_run) |-> run_len_q == 10'(BUILT_IN_SELF_CHECK_CYCLES))
    else $error("self-test length wrong");
  a_built_in_self_check_pass: assert property (bst_q == BST_CHECK |=> pass_q == ($past(crc_q) == BUILT_IN_SELF_CHECK_SIGNATURE))
    else $error("pass flag wrong");
  a_or_clamp: assert property (!built_in_self_check_run && test_q[3:0] == TM_OFF && $signed(core_sample[0]) > MAXH
    |-> src_w[0] == {1'b1, {W{1'b1}}}) else $error("over-range not clamped");
  a_pn_reset: assert property (test_q[TM_RST_LONG_BIT] |=> pnl_q == PN_LONG_SEED)
    else $error("pattern generator not reset");
  a_dco_data: assert property ($rose(dco_q) |-> $stable(data_out)) else $error("data moved at clock edge");

  c_built_in_self_check_pass: cover property (bst_q == BST_CHECK ##1 pass_q);
  c_test_out: cover property (test_q[3:0] == TM_PNL ##[1:40] $rose(dco_q));
  c_buf_full: cover property (cnt_q == 2'h2 && buf_wvalid);
  c_pd_exit: cover property (pd ##1 !pd ##2 data_oe == '1);

endmodule

// file: testbench/dab_capture_model.sv
// Capture register on the far side of the parallel sample outputs
`timescale 1ns/10ps
module dab_capture_model
  import dab_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       stall,
  input  wire logic                       invert,
  input  wire logic [NCH-1:0][DAB_W-1:0]  data_out,
  input  wire logic [NCH-1:0]             over_range_out,
  input  wire logic [NCH-1:0]             data_clock_out,
  input  wire logic [NCH-1:0]             data_oe,
  output logic                            capture_ready,
  output logic      [NCH-1:0][DAB_W-1:0]  cap_data,
  output logic      [NCH-1:0]             cap_or
);
  logic [NCH-1:0] dco_q;

  assign capture_ready = !stall;

  ////////////////////////////////////////////////////////////////////////////////
  // Only the selected data clock edge is trusted; a three-stated channel is never captured
  always_ff @(posedge clock)
  begin
    dco_q <= data_clock_out ^ {NCH{invert}};
    for (int c = 0; c < NCH; c++)
      if (data_oe[c] && (data_clock_out[c] ^ invert) && !dco_q[c])
      begin
        cap_data[c] <= data_out[c];
        cap_or[c]   <= over_range_out[c];
      end
  end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the dual converter back end
`timescale 1ns/10ps
module testbench
  import dab_pkg::*;
;
  logic                       clock;
  logic                       sys_rst;
  logic                       power_down_pin;
  logic                       output_disable_pin;
  logic                       format_strap_pin;
  logic                       serial_mode;
  logic                       reg_we;
  logic                       reg_re;
  logic                       sample_tick = 1'b0;
  logic                       stall;
  logic                       invert;
  logic                       core_accept;
  logic                       capture_ready;
  logic                       core_enable;
  logic                       reference_on;
  logic [7:0]                 reg_addr;
  logic [7:0]                 reg_wdata;
  logic [7:0]                 reg_rdata;
  logic [7:0]                 r;
  logic [2:0]                 tick_cnt = 3'd0;
  logic [NCH-1:0][DAB_W+2:0]  core_sample;
  logic [NCH-1:0][DAB_W-1:0]  data_out;
  logic [NCH-1:0][DAB_W-1:0]  cap_data;
  logic [NCH-1:0]             over_range_out;
  logic [NCH-1:0]             data_clock_out;
  logic [NCH-1:0]             data_oe;
  logic [NCH-1:0]             cap_or;
  logic [7:0]                 ra [6] = '{8'h05, 8'h08, 8'h0d, 8'h0e, 8'h14, 8'h30};
  logic [7:0]                 rv [6] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int                         n_mismatch;
  int                         n_tests;

  // Reference signature: zero words fill the pipe, then the restarted source reaches its end
  function automatic logic [15:0] ref_sig();
    logic [15:0] p;
    logic [15:0] c;
    logic [21:0] w;
    p = BUILT_IN_SELF_CHECK_SEED;
    c = CRC_SEED;
    for (int j = 0; j < BUILT_IN_SELF_CHECK_CYCLES; j++)
    begin
      w = '0;
      if (j >= PIPE_DEPTH)
      begin
        w = {1'b0, p[DAB_W-1:0], 1'b0, p[DAB_W-1:0]};
        p = {p[14:0], p[15] ^ p[13] ^ p[12] ^ p[10]};
      end
      for (int i = 21; i >= 0; i--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction

  localparam logic [15:0] SIG = ref_sig();

  dab_backend #(.BUILT_IN_SELF_CHECK_SIGNATURE(SIG)) dab_backend_i (.clock(clock), .sys_rst(sys_rst),
    .power_down_pin(power_down_pin),
    .output_disable_pin(output_disable_pin), .format_strap_pin(format_strap_pin), .serial_mode(serial_mode),
    .reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_tick(sample_tick), .core_sample(core_sample), .core_accept(core_accept),
    .capture_ready(capture_ready), .data_out(data_out), .over_range_out(over_range_out),
    .data_clock_out(data_clock_out), .data_oe(data_oe), .core_enable(core_enable), .reference_on(reference_on));

  dab_capture_model dab_capture_model_i (.clock(clock), .stall(stall), .invert(invert), .data_out(data_out),
    .over_range_out(over_range_out), .data_clock_out(data_clock_out), .data_oe(data_oe),
    .capture_ready(capture_ready), .cap_data(cap_data), .cap_or(cap_or));

  ////////////////////////////////////////////////////////////////////////////////
  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  // One sample edge every 200 ns keeps the two-entry buffer from overflowing
  always @(negedge clock)
  begin
    tick_cnt    <= tick_cnt + 3'd1;
    sample_tick <= (tick_cnt == 3'd7);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_we    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clock);
    reg_we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_re   = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_re = 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic do_reset;
    sys_rst = 1'b1;
    wait_clk(3);
    sys_rst = 1'b0;
    wait_clk(8);
  endtask

  // Half-LSB input to output code; gray is taken from the offset-binary code
  function automatic logic [9:0] fx(input int v, input int f);
    logic [9:0] c;
    c = (v < 0) ? 10'h000 : (v > 2047) ? 10'h3ff : 10'(v >>> 1);
    if (f == 1)
      c[9] = ~c[9];
    if (f == 2)
      c = c ^ (c >> 1);
    return c;
  endfunction

  task automatic word(input int v, input int f);
    core_sample = {2{13'(v)}};
    wait_clk(14 * 8);
    chk("data a", 16'(cap_data[0]), 16'(fx(v, f)));
    chk("data b", 16'(cap_data[1]), 16'(fx(v, f)));
    chk("range", 16'(cap_or), {14'h0, {2{(v < 0 || v > 2047)}}});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_mismatch = 0;
    n_tests = 0;
    {power_down_pin, output_disable_pin, format_strap_pin, reg_we, reg_re, stall, invert} = 7'h00;
    serial_mode = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    core_sample = '0;
    do_reset();
    chk("reset oe", 16'(data_oe), 16'h0003);
    format_strap_pin = 1'b1;
    word(1024, 1);
    format_strap_pin = 1'b0;
    word(1024, 0);
    $display("strap test done");
    serial_mode = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i], r);
      chk("reset reg", 16'(r), 16'(rv[i]));
    end
    for (int f = 0; f < 3; f++)
    begin
      wr(REG_OUT_MODE, 8'(f));
      word(-3, f);
      word(1024, f);
      word(1500, f);
      word(4000, f);
    end
    wr(REG_OUT_MODE, 8'h00);
    word(1500, 0);
    while (tick_cnt != 3'd1)
      @(negedge clock);
    core_sample = {2{13'(600)}};
    wait_clk(7 * 8);
    chk("latency early", 16'(cap_data[0]), 16'(fx(1500, 0)));
    wait_clk(4 * 8);
    chk("latency late", 16'(cap_data[0]), 16'(fx(600, 0)));
    $display("format test done");
    stall = 1'b1;
    wait_clk(6 * 8);
    chk("buffer full", 16'(core_accept), 16'h0000);
    stall = 1'b0;
    wait_clk(3 * 8);
    chk("buffer drained", 16'(core_accept), 16'h0001);
    invert = 1'b1;
    wr(REG_OUT_MODE, 8'h80);
    word(300, 0);
    invert = 1'b0;
    wr(REG_OUT_MODE, 8'h00);
    $display("capture test done");
    output_disable_pin = 1'b1;
    wait_clk(8);
    chk("oe pin high", 16'(data_oe), 16'h0000);
    output_disable_pin = 1'b0;
    wait_clk(8);
    chk("oe pin low", 16'(data_oe), 16'h0003);
    wr(REG_CHAN_SEL, 8'h01);
    wr(REG_OUT_MODE, 8'h10);
    wait_clk(3);
    chk("chan disable", 16'(data_oe), 16'h0002);
    wr(REG_OUT_MODE, 8'h00);
    wr(REG_CHAN_SEL, 8'h03);
    wr(REG_POWER, 8'h02);
    wait_clk(3);
    chk("standby", {13'h0, reference_on, core_enable, data_oe == 2'b00}, 16'h0005);
    wr(REG_POWER, 8'h01);
    wait_clk(3);
    chk("reg down", {13'h0, reference_on, core_enable, data_oe == 2'b00}, 16'h0001);
    wr(REG_POWER, 8'h00);
    power_down_pin = 1'b1;
    wait_clk(8);
    chk("pin down", {14'h0, reference_on, data_oe == 2'b00}, 16'h0001);
    power_down_pin = 1'b0;
    wait_clk(8);
    chk("pin up", {13'h0, core_enable, data_oe}, 16'h0007);
    $display("power test done");
    // A zero input leaves only zero words in the pipe before the self-test starts
    core_sample = '0;
    do_reset();
    wr(REG_BUILT_IN_SELF_CHECK, 8'h05);
    wait_clk(5);
    rd(REG_BUILT_IN_SELF_CHECK_RES, r);
    chk("self test busy", 16'(r[RES_BUSY_BIT]), 16'h0001);
    chk("self test oe", 16'(data_oe), 16'h0003);
    wait_clk(530);
    rd(REG_BUILT_IN_SELF_CHECK_RES, r);
    chk("self test end", 16'(r), 16'h0001);
    rd(REG_BUILT_IN_SELF_CHECK, r);
    chk("self test enable", 16'(r[BUILT_IN_SELF_CHECK_EN_BIT]), 16'h0000);
    wr(REG_BUILT_IN_SELF_CHECK, 8'h01);
    wait_clk(540);
    rd(REG_BUILT_IN_SELF_CHECK_RES, r);
    chk("continued run", 16'(r), 16'h0000);
    $display("self test done");
    core_sample = {2{13'(4000)}};
    wr(REG_TEST, 8'(TM_MID));
    wait_clk(14 * 8);
    chk("mid pattern", 16'(cap_data[0]), 16'h0200);
    wr(REG_OUT_MODE, 8'h01);
    wait_clk(14 * 8);
    chk("mid twos", 16'(cap_data[0]), 16'h0000);
    wr(REG_OUT_MODE, 8'h00);
    wr(REG_TEST, 8'(TM_POS));
    wait_clk(14 * 8);
    chk("pos pattern", 16'(cap_data[1]), 16'h03ff);
    wr(REG_TEST, 8'(TM_NEG));
    wait_clk(14 * 8);
    chk("neg pattern", 16'(cap_data[1]), 16'h0000);
    wr(REG_TEST, 8'h10 | 8'(TM_PNL));
    wait_clk(14 * 8);
    chk("held pn", 16'(cap_data[0]), 16'(PN_LONG_SEED[DAB_W-1:0]));
    wait_clk(5 * 8);
    chk("held pn later", 16'(cap_data[1]), 16'(PN_LONG_SEED[DAB_W-1:0]));
    wr(REG_TEST, 8'(TM_OFF));
    $display("pattern test done");
    final_report();
  end

  // Whole run is near 3800 cycles; this leaves ample margin
  initial
  begin
    wait_clk(30000);
    n_mismatch++;
    final_report();
  end
endmodule
